// ===== bench/interp_zero_stuff_datapath_test.sv
`timescale 1ns/1ps
module interp_zero_stuff_datapath_test;
    logic                   clock_in = 1'b0;
    logic                   rst_in = 1'b1;
    logic                   filter_response_select = 1'b0;
    logic                   midscale_insert_enable = 1'b0;
    logic                   sleep = 1'b0;
    logic [13:0]            word = 14'h3123;
    logic [13:0]            sample;
    logic                   strobe;
    logic                   lock;
    izs_pkg::izs_dac_word_t dac;
    int                     n_mismatch = 0;
    int                     cmp_count = 0;
    // 125 MHz core clock
    always #4 clock_in = ~clock_in;
    izs_source_model src_u (.clock_in(clock_in), .strobe_in(strobe),
        .word_in(word), .sample_out(sample));
    izs_datapath dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .sample_in(sample), .sleep_in(sleep), .dac_out(dac),
        .filter_response_select_in(filter_response_select),
        .midscale_insert_enable_in(midscale_insert_enable),
        .sample_strobe_out(strobe), .multiplier_lock_flag_out(lock));
    // compare and count
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for a capture marker
    task automatic wait_strobe();
        for (int k = 0; strobe !== 1'b1; k++) begin
            @(posedge clock_in);
            #1;
            if (k > 64) begin
                n_mismatch++;
                finish_test();
            end
        end
    endtask
    // steady word through one mode, then one group of four outputs
    task automatic mode_case(input logic [1:0] m, input logic [13:0] w);
        logic [13:0] e;
        e = w ^ izs_pkg::MSB_FLIP;
        e = (m[0] && e == 14'h2000) ? 14'h1FFF : (m[0] ? -e : e);
        e = e ^ izs_pkg::MSB_FLIP;
        @(posedge clock_in);
        filter_response_select <= m[0];
        midscale_insert_enable <= m[1];
        word <= w;
        repeat (120) @(posedge clock_in);
        #1;
        wait_strobe();
        // skip the latch edge; the even sample leads the next group
        @(posedge clock_in);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in);
            #1;
            check(dac, {!i[0] || m[1], (m[1] && i[0]) ?
                izs_pkg::MIDSCALE_CODE : (i < 2 ? e : w)});
        end
    endtask
    // sleep parks the output and stops captures
    task automatic sleep_case();
        @(posedge clock_in);
        sleep <= 1'b1;
        repeat (6) @(posedge clock_in);
        #1;
        check({strobe, dac.code}, {1'b0, izs_pkg::MIDSCALE_CODE});
        @(posedge clock_in);
        sleep <= 1'b0;
        wait_strobe();
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clock_in);
        #1;
        check(dac, {1'b0, izs_pkg::MIDSCALE_CODE});
        check({14'h0000, lock}, 15'h0000);
        @(posedge clock_in);
        rst_in <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            mode_case(m[1:0], m[2] ? 14'h0000 : 14'h3123);
        end
        check({14'h0000, lock}, 15'h0001);
        sleep_case();
        mode_case(2'h3, 14'h3FFF);
        finish_test();
    end
endmodule
bind izs_datapath izs_datapath_props chk_u (.clock_in(clock_in),
    .rst_in(rst_in), .sample_in(sample_in), .sleep_in(sleep_in),
    .filter_response_select_in(filter_response_select_in),
    .midscale_insert_enable_in(midscale_insert_enable_in),
    .dac_out(dac_out), .sample_strobe_out(sample_strobe_out),
    .multiplier_lock_flag_out(multiplier_lock_flag_out));

// ===== bench/izs_datapath_props.sv
`timescale 1ns/1ps
// port-level checks of the datapath output sequence
module izs_datapath_props (
    // clock, reset, inputs
    input wire logic              clock_in,
    input wire logic              rst_in,
    input wire logic [13:0]       sample_in,
    input wire logic              filter_response_select_in,
    input wire logic              midscale_insert_enable_in,
    input wire logic              sleep_in,
    // outputs
    input izs_pkg::izs_dac_word_t dac_out,
    input wire logic              sample_strobe_out,
    input wire logic              multiplier_lock_flag_out
);
    // one domain, reset disables all
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire logic st = sample_strobe_out;
    wire logic stf = midscale_insert_enable_in && !sleep_in;
    wire logic nst = !midscale_insert_enable_in && !sleep_in;
    // captures are four core cycles apart
    property p_gap; st |=> !st [*3]; endproperty
    a_gap: assert property (p_gap) else $error("strobe too close");
    property p_next; st ##0 !sleep_in [*5] |-> st; endproperty
    a_next: assert property (p_next) else $error("capture missed");
    property p_upd; st ##0 !sleep_in [*3] |-> dac_out.update; endproperty
    a_upd: assert property (p_upd) else $error("no even update");
    property p_stuf_upd; stf [*8] |-> dac_out.update; endproperty
    a_stuf_upd: assert property (p_stuf_upd) else $error("4x gap");
    property p_mid_ev;
        st ##0 stf [*4] |-> dac_out.code == izs_pkg::MIDSCALE_CODE;
    endproperty
    a_mid_ev: assert property (p_mid_ev) else $error("no mid");
    property p_mid_od;
        st ##0 stf [*6] |-> dac_out.code == izs_pkg::MIDSCALE_CODE;
    endproperty
    a_mid_od: assert property (p_mid_od) else $error("no mid");
    property p_hold;
        st ##0 nst [*4] |-> $stable(dac_out.code) && !dac_out.update;
    endproperty
    a_hold: assert property (p_hold) else $error("2x slot wrong");
    property p_park;
        sleep_in [*3] |-> dac_out.code == izs_pkg::MIDSCALE_CODE && !st;
    endproperty
    a_park: assert property (p_park) else $error("not parked");
    // main scenarios reached
    c_stuf: cover property (st && midscale_insert_enable_in);
    c_high: cover property (st && filter_response_select_in);
    c_sleep: cover property (sleep_in [*3]);
endmodule

// ===== bench/izs_source_model.sv
`timescale 1ns/1ps
// sample source: word valid for the capture, junk just after a strobe
module izs_source_model (
    input  wire logic        clock_in,
    input  wire logic        strobe_in,
    input  wire logic [13:0] word_in,
    output logic [13:0]      sample_out
);
    logic [13:0] hold_q = 14'h0000;
    assign sample_out = hold_q;
    // word_in registered every core edge, inverted on the edge just after a strobe
    always @(posedge clock_in) begin
        hold_q <= strobe_in ? ~word_in : word_in;
    end
endmodule

// ===== include/izs_pkg.sv
package izs_pkg;

    // sample format
    localparam int SAMPLE_W = 14;
    localparam logic [13:0] MIDSCALE_CODE = 14'h2000;
    localparam logic [13:0] MSB_FLIP      = 14'h2000;

    // half-band geometry: 43 taps, 11 symmetric nonzero pairs
    localparam int TAPS      = 43;
    localparam int PAIRS     = 11;
    localparam int LINE_LEN  = 22;
    localparam int CENTER_IX = 11;
    localparam int COEF_W    = 16;
    localparam int COEF_FRAC = 15;
    localparam int ACC_W     = 36;

    // pair weights in Q15, outermost last; they sum to one half
    localparam logic signed [15:0] PAIR_COEF [PAIRS] = '{
        16'sh517C, -16'sh1A7C, 16'sh0EA6, -16'sh092E, 16'sh0604,
        -16'sh03F2, 16'sh0280, -16'sh0186, 16'sh00DC, -16'sh0064,
        16'sh0004
    };

    // phase of the 4x update clock against the 1x sample clock
    localparam logic [1:0] PH_CAPTURE = 2'h0;
    localparam logic [1:0] PH_LATCH   = 2'h1;
    localparam logic [1:0] PH_EVEN    = 2'h2;
    localparam logic [1:0] PH_EVEN_Z  = 2'h3;
    localparam logic [1:0] PH_RESET   = 2'h0;

    // clock multiplier settle time before lock is reported
    localparam int CLK_PERIOD_PS = 8000;
    localparam int LOCK_TIME_NS  = 1000;
    localparam int LOCK_CYCLES   =
        (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_CNT_W    = 8;

    // word handed to the converter core
    typedef struct packed {
        logic        update;
        logic [13:0] code;
    } izs_dac_word_t;

endpackage

// ===== verilog/izs_datapath.sv
`timescale 1ns/1ps
// Overview of operation
// - each 14-bit input word is captured at the sample clock edge
// - every captured sample yields exactly two filter output samples
// - response select picks low/high pass; insert enable picks stuffing
// - low-pass response keeps baseband and rejects first image
// - high-pass response rejects baseband and passes upper image
// - without stuffing, each filter output reaches the core at 2x rate
// - with stuffing, the core is updated at 4x the input rate
// - input up to 160 MSPS; core update path up to 400 MSPS
// - sleep input halts conversion and parks the output
// - stuffing inserts midscale after every filter output sample
// - filter is a 43-tap symmetric half-band, zero taps skipped
// - high-pass negates only the center coefficient
module izs_datapath (
    // clock and reset (clock is the 4x core update clock)
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    // sample source
    input  wire logic [13:0]           sample_in,
    // mode and power control
    input  wire logic                  filter_response_select_in,
    input  wire logic                  midscale_insert_enable_in,
    input  wire logic                  sleep_in,
    // converter core side
    output izs_pkg::izs_dac_word_t     dac_out,
    // 1x sample clock marker and lock indication
    output logic                       sample_strobe_out,
    output logic                       multiplier_lock_flag_out
);

    logic [1:0]                      phase_q;
    logic signed [13:0]              line_q [izs_pkg::LINE_LEN];
    logic signed [13:0]              odd_d;
    logic signed [13:0]              even_q;
    logic signed [13:0]              odd_q;
    logic signed [13:0]              center_s;
    logic signed [13:0]              even_d;
    logic [izs_pkg::LOCK_CNT_W-1:0]  lock_cnt_q;
    logic                            lock_q;
    izs_pkg::izs_dac_word_t          dac_q;
    logic                            strobe_q;

    // schedule of one input sample, counted in core update edges:
    //   edge c   : phase 0, the word on sample_in enters the delay line
    //   edge c+1 : phase 1, both filter outputs are latched together
    //   edge c+2 : phase 2, the even output goes to the core, update high
    //   edge c+3 : phase 3, midscale when stuffing, else even repeated
    //   edge c+4 : phase 0, the odd output goes out, next word captured
    //   edge c+5 : phase 1, midscale when stuffing, else odd repeated
    // hazards and limits worth knowing:
    //   the filter outputs are latched one edge after the capture, so the
    //   pair adder has a full core cycle to settle from the new line
    //   the outputs of one sample are held in even_q and odd_q for four
    //   edges, which keeps the mux free of any path from the delay line
    //   a mode change lands at the next edge; the first group after it
    //   may mix both modes, so the source treats the modes as static
    //   sleep freezes the phase and the line instead of clearing them,
    //   so the first groups after waking still use the old history
    //   the core sees update low in repeat slots, so a 2x core can use
    //   update as its own load enable without a second clock
    //   without stuffing the core update rate is half the edge rate,
    //   with stuffing it equals the edge rate
    //   reset puts the phase at capture, so the first edge after release
    //   takes a word; the source must have one ready by then
    // phase of the sample clock inside four update cycles; frozen asleep
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            phase_q <= izs_pkg::PH_RESET;
        end else if (!sleep_in) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // input latch and delay line, offset binary turned signed
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < izs_pkg::LINE_LEN; i++) begin
                line_q[i] <= '0;
            end
        end else if (!sleep_in && phase_q == izs_pkg::PH_CAPTURE) begin
            line_q[0] <= sample_in ^ izs_pkg::MSB_FLIP;
            for (int i = 1; i < izs_pkg::LINE_LEN; i++) begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    // odd phase of the half-band: pairs only, even taps are zero
    izs_pair_mac u_mac (
        .line_in (line_q),
        .odd_out (odd_d)
    );

    // even phase is the center tap alone; high pass negates it
    assign center_s = line_q[izs_pkg::CENTER_IX];
    always_comb begin
        if (!filter_response_select_in) begin
            even_d = center_s;
        end else if (center_s == -14'sh2000) begin
            even_d = 14'sh1FFF; // clip the one code with no negative
        end else begin
            even_d = -center_s;
        end
    end

    // hold both filter outputs of one input sample
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            even_q <= '0;
            odd_q  <= '0;
        end else if (!sleep_in && phase_q == izs_pkg::PH_LATCH) begin
            even_q <= even_d;
            odd_q  <= odd_d;
        end
    end

    // output mux: filter sample, then midscale or a repeat
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dac_q <= '{update: 1'b0, code: izs_pkg::MIDSCALE_CODE};
        end else if (sleep_in) begin
            dac_q <= '{update: 1'b0, code: izs_pkg::MIDSCALE_CODE};
        end else begin
            unique case (phase_q)
                izs_pkg::PH_EVEN: begin
                    dac_q.code   <= even_q ^ izs_pkg::MSB_FLIP;
                    dac_q.update <= 1'b1;
                end
                izs_pkg::PH_EVEN_Z: begin
                    dac_q.code   <= midscale_insert_enable_in ?
                        izs_pkg::MIDSCALE_CODE :
                        (even_q ^ izs_pkg::MSB_FLIP);
                    dac_q.update <= midscale_insert_enable_in;
                end
                izs_pkg::PH_CAPTURE: begin
                    dac_q.code   <= odd_q ^ izs_pkg::MSB_FLIP;
                    dac_q.update <= 1'b1;
                end
                izs_pkg::PH_LATCH: begin
                    dac_q.code   <= midscale_insert_enable_in ?
                        izs_pkg::MIDSCALE_CODE :
                        (odd_q ^ izs_pkg::MSB_FLIP);
                    dac_q.update <= midscale_insert_enable_in;
                end
            endcase
        end
    end

    // 1x clock marker: registered pulse in the cycle after the capture edge
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= !sleep_in && phase_q == izs_pkg::PH_CAPTURE;
        end
    end

    // lock flag rises after the settle count, never drops until reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            lock_cnt_q <= '0;
            lock_q     <= 1'b0;
        end else if (lock_cnt_q ==
                     izs_pkg::LOCK_CNT_W'(izs_pkg::LOCK_CYCLES - 1)) begin
            lock_q <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end
    end

    assign dac_out                  = dac_q;
    assign sample_strobe_out        = strobe_q;
    assign multiplier_lock_flag_out = lock_q;

endmodule

// ===== verilog/izs_pair_mac.sv
`timescale 1ns/1ps
// odd-phase half-band output: symmetric pairs pre-added, then weighted
module izs_pair_mac (
    // delay line of signed samples, newest at index 0
    input  wire logic signed [13:0] line_in [izs_pkg::LINE_LEN],
    // rounded, saturated odd-phase sample
    output logic signed [13:0]      odd_out
);

    logic signed [izs_pkg::ACC_W-1:0] prod [izs_pkg::PAIRS];
    logic signed [izs_pkg::ACC_W-1:0] acc;
    logic signed [izs_pkg::ACC_W-1:0] rnd;

    // one product per symmetric pair around the center gap
    for (genvar j = 0; j < izs_pkg::PAIRS; j++) begin : g_pair
        logic signed [14:0] psum;
        assign psum = 15'(line_in[izs_pkg::CENTER_IX - 1 - j])
                    + 15'(line_in[izs_pkg::CENTER_IX + j]);
        // widen both operands first so the product keeps every bit
        assign prod[j] = izs_pkg::ACC_W'(psum)
                       * izs_pkg::ACC_W'(izs_pkg::PAIR_COEF[j]);
    end

    // sum, round and clip back to fourteen bits
    always_comb begin
        acc = '0;
        for (int j = 0; j < izs_pkg::PAIRS; j++) begin
            acc = acc + prod[j];
        end
        // weights sum to one half per side, so a full Q15 shift gives unity
        rnd = (acc + (izs_pkg::ACC_W'(1) <<< (izs_pkg::COEF_FRAC - 1)))
              >>> izs_pkg::COEF_FRAC;
        if (rnd > izs_pkg::ACC_W'(8191)) begin
            odd_out = 14'sh1FFF;
        end else if (rnd < -izs_pkg::ACC_W'(8192)) begin
            odd_out = -14'sh2000;
        end else begin
            odd_out = rnd[13:0];
        end
    end

endmodule
